//--- verilog/fifo_framing_collision_regs.sv
// Register slice: FIFO level and flush, warning threshold, timer strobes,
// bit framing and first collision position.
// Assumes one register access per cycle, decoded upstream from the host interface.
`timescale 1ns/10ps
module fifo_framing_collision_regs #(
    parameter int DEPTH = fifo_framing_collision_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [5:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Modem side
    input wire logic transceive_active_in,
    input wire logic rx_frame_start_in,
    input wire logic rx_frame_end_in,
    input wire logic [2:0] rx_final_bits_in,
    input wire logic clash_event_in,
    input wire logic [fifo_framing_collision_pkg::NUM_W-1:0] clash_bit_number_in,
    // Status and control outputs
    output logic [6:0] fifo_byte_count_out,
    output logic fifo_overrun_flag_out,
    output logic fifo_clear_out,
    output logic near_full_flag_out,
    output logic near_empty_flag_out,
    output logic timer_halt_out,
    output logic timer_launch_out,
    output logic tx_launch_out,
    output logic [2:0] rx_first_bit_offset_out,
    output logic [2:0] tx_final_byte_bit_count_out,
    output logic keep_bits_after_clash_out,
    output logic clear_bits_after_clash_out
);
    import fifo_framing_collision_pkg::*;

    if (DEPTH < 1 || DEPTH > 127) begin
        $error("DEPTH must fit the 7-bit count");
    end

    // ========================================
    // State
    typedef struct packed {
        logic [6:0] count;
        logic overrun;
        logic clear_pulse;
        logic [5:0] threshold;
        logic near_full;
        logic near_empty;
        logic halt;
        logic launch;
        logic tx;
        logic [2:0] rx_last;
        logic [2:0] rx_offset;
        logic [2:0] tx_last;
        logic keep;
        logic invalid;
        logic [4:0] position;
        logic clashed;
        logic discard;
        logic [7:0] rdata;
    } state_s;

    state_s state;
    state_s next_state;

    localparam logic [7:0] DEPTH_W = 8'(DEPTH);

    function automatic logic near_full_f(input logic [6:0] cnt, input logic [5:0] thr);
        near_full_f = (DEPTH_W - {1'b0, cnt}) <= {2'b00, thr};
    endfunction

    function automatic logic near_empty_f(input logic [6:0] cnt, input logic [5:0] thr);
        near_empty_f = cnt <= {1'b0, thr};
    endfunction

    function automatic logic acc_f(input logic strobe, input logic [5:0] a,
                                   input logic [5:0] b);
        acc_f = strobe && (a == b);
    endfunction

    // ========================================
    // Next state
    always_comb begin
        next_state = state;
        next_state.halt = 1'b0;
        next_state.launch = 1'b0;
        next_state.tx = 1'b0;
        next_state.clear_pulse = 1'b0;
        if (acc_f(reg_wr_in, reg_addr_in, ADDR_FIFO_PORT)) begin
            if (state.count >= DEPTH_W[6:0]) begin
                next_state.overrun = 1'b1;
            end else begin
                next_state.count = state.count + 7'h01;
            end
        end else if (acc_f(reg_rd_in, reg_addr_in, ADDR_FIFO_PORT)) begin
            if (state.count != 7'h00) begin
                next_state.count = state.count - 7'h01;
            end
        end
        if (acc_f(reg_wr_in, reg_addr_in, ADDR_FIFO_FILL_LEVEL)
                && reg_wdata_in[FIFO_CLEAR_BIT]) begin
            next_state.count = 7'h00;
            next_state.overrun = 1'b0;
            next_state.clear_pulse = 1'b1;
        end
        if (acc_f(reg_wr_in, reg_addr_in, ADDR_FIFO_WARNING_THRESHOLD)) begin
            next_state.threshold = reg_wdata_in[5:0];
        end
        if (acc_f(reg_wr_in, reg_addr_in, ADDR_MISC_CONTROL)) begin
            next_state.halt = reg_wdata_in[TIMER_HALT_BIT];
            next_state.launch = reg_wdata_in[TIMER_LAUNCH_BIT]
                && !reg_wdata_in[TIMER_HALT_BIT];
        end
        if (acc_f(reg_wr_in, reg_addr_in, ADDR_BIT_FRAMING_CONTROL)) begin
            next_state.tx = reg_wdata_in[TX_LAUNCH_BIT] && transceive_active_in;
            next_state.rx_offset = reg_wdata_in[RX_OFFSET_LSB +: 3];
            next_state.tx_last = reg_wdata_in[2:0];
        end
        if (acc_f(reg_wr_in, reg_addr_in, ADDR_COLLISION_INFO)) begin
            next_state.keep = reg_wdata_in[KEEP_BITS_BIT];
        end
        if (rx_frame_end_in) begin
            next_state.rx_last = rx_final_bits_in;
        end
        if (rx_frame_start_in) begin
            next_state.clashed = 1'b0;
            next_state.invalid = 1'b1;
            next_state.position = 5'h00;
        end else if (clash_event_in && !state.clashed) begin
            next_state.clashed = 1'b1;
            if (clash_bit_number_in >= NUM_W'(1) && clash_bit_number_in <= NUM_W'(CLASH_RANGE))
            begin
                next_state.invalid = 1'b0;
                next_state.position = clash_bit_number_in[4:0];
            end else begin
                next_state.invalid = 1'b1;
            end
        end
        next_state.discard = next_state.clashed && !next_state.keep;
        next_state.near_full = near_full_f(next_state.count, next_state.threshold);
        next_state.near_empty = near_empty_f(next_state.count, next_state.threshold);
        next_state.rdata = 8'h00;
        if (reg_rd_in) begin
            if (reg_addr_in == ADDR_FIFO_FILL_LEVEL) begin
                next_state.rdata = {1'b0, state.count};
            end else if (reg_addr_in == ADDR_FIFO_WARNING_THRESHOLD) begin
                next_state.rdata = {2'b00, state.threshold};
            end else if (reg_addr_in == ADDR_MISC_CONTROL) begin
                next_state.rdata = MISC_CONTROL_RESERVED | {5'h00, state.rx_last};
            end else if (reg_addr_in == ADDR_BIT_FRAMING_CONTROL) begin
                next_state.rdata = {1'b0, state.rx_offset, 1'b0, state.tx_last};
            end else if (reg_addr_in == ADDR_COLLISION_INFO) begin
                next_state.rdata = {state.keep, 1'b0, state.invalid, state.position};
            end
        end
    end

    // ========================================
    // Registers
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= '0;
            state.threshold <= THRESHOLD_RESET;
            state.keep <= KEEP_BITS_RESET;
            state.invalid <= CLASH_INVALID_RESET;
            state.near_empty <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata_out = state.rdata;
    assign fifo_byte_count_out = state.count;
    assign fifo_overrun_flag_out = state.overrun;
    assign fifo_clear_out = state.clear_pulse;
    assign near_full_flag_out = state.near_full;
    assign near_empty_flag_out = state.near_empty;
    assign timer_halt_out = state.halt;
    assign timer_launch_out = state.launch;
    assign tx_launch_out = state.tx;
    assign rx_first_bit_offset_out = state.rx_offset;
    assign tx_final_byte_bit_count_out = state.tx_last;
    assign keep_bits_after_clash_out = state.keep;
    assign clear_bits_after_clash_out = state.discard;

    // ========================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence flush_s;
        reg_wr_in && reg_addr_in == ADDR_FIFO_FILL_LEVEL && reg_wdata_in[FIFO_CLEAR_BIT];
    endsequence
    sequence port_write_s;
        reg_wr_in && reg_addr_in == ADDR_FIFO_PORT;
    endsequence
    sequence port_read_s;
        reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_FIFO_PORT;
    endsequence
    sequence halt_write_s;
        reg_wr_in && reg_addr_in == ADDR_MISC_CONTROL && reg_wdata_in[TIMER_HALT_BIT];
    endsequence
    sequence framing_write_s;
        reg_wr_in && reg_addr_in == ADDR_BIT_FRAMING_CONTROL;
    endsequence

    fifo_flush_a: assert property (flush_s |=> state.count == 7'h00 && !state.overrun)
        else $error("flush did not clear count and overrun");
    clear_pulse_a: assert property (
        fifo_clear_out |-> fifo_byte_count_out == 7'h00 && !fifo_overrun_flag_out)
        else $error("clear pulse without empty fifo");
    clear_reads_a: assert property (
        reg_rd_in && reg_addr_in == ADDR_FIFO_FILL_LEVEL
        |=> !reg_rdata_out[FIFO_CLEAR_BIT] && reg_rdata_out[6:0] == $past(state.count))
        else $error("fill level read wrong");
    count_inc_a: assert property (
        port_write_s ##0 (state.count < DEPTH_W[6:0])
        |=> fifo_byte_count_out == $past(fifo_byte_count_out) + 7'h01)
        else $error("count did not increment");
    count_dec_a: assert property (
        port_read_s ##0 (fifo_byte_count_out != 7'h00)
        |=> fifo_byte_count_out == $past(fifo_byte_count_out) - 7'h01)
        else $error("count did not decrement");
    count_hold_a: assert property (
        !reg_wr_in && !reg_rd_in |=> $stable(fifo_byte_count_out))
        else $error("count moved without access");
    near_full_a: assert property (
        near_full_flag_out
        == ((DEPTH_W - {1'b0, fifo_byte_count_out}) <= {2'b00, state.threshold}))
        else $error("near full flag wrong");
    near_empty_a: assert property (
        near_empty_flag_out == (fifo_byte_count_out <= {1'b0, state.threshold}))
        else $error("near empty flag wrong");
    thr_write_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_FIFO_WARNING_THRESHOLD
        |=> state.threshold == $past(reg_wdata_in[5:0]))
        else $error("threshold not written");
    timer_halt_a: assert property (halt_write_s |=> timer_halt_out)
        else $error("halt pulse missing");
    halt_cause_a: assert property (
        timer_halt_out |-> $past(reg_wr_in) && $past(reg_wdata_in[TIMER_HALT_BIT])
        && $past(reg_addr_in) == ADDR_MISC_CONTROL)
        else $error("halt pulse without cause");
    timer_launch_a: assert property (
        timer_launch_out |-> !timer_halt_out && $past(reg_wr_in)
        && $past(reg_wdata_in[TIMER_LAUNCH_BIT]) && $past(reg_addr_in) == ADDR_MISC_CONTROL)
        else $error("launch pulse without cause");
    misc_read_a: assert property (
        reg_rd_in && reg_addr_in == ADDR_MISC_CONTROL
        |=> reg_rdata_out[7:6] == 2'b00 && reg_rdata_out[2:0] == $past(state.rx_last))
        else $error("control read wrong");
    rx_last_a: assert property (
        rx_frame_end_in |=> state.rx_last == $past(rx_final_bits_in))
        else $error("last bit count not loaded");
    tx_gate_a: assert property (
        tx_launch_out |-> $past(transceive_active_in) && $past(reg_wr_in)
        && $past(reg_wdata_in[TX_LAUNCH_BIT]) && $past(reg_addr_in) == ADDR_BIT_FRAMING_CONTROL)
        else $error("transmission started outside transceive");
    tx_start_a: assert property (
        framing_write_s ##0 (reg_wdata_in[TX_LAUNCH_BIT] && transceive_active_in)
        |=> tx_launch_out)
        else $error("send trigger ignored");
    rx_offset_a: assert property (
        framing_write_s |=> rx_first_bit_offset_out == $past(reg_wdata_in[RX_OFFSET_LSB +: 3]))
        else $error("receive offset not written");
    tx_final_a: assert property (
        framing_write_s |=> tx_final_byte_bit_count_out == $past(reg_wdata_in[2:0]))
        else $error("transmit last bits not written");
    overrun_set_a: assert property (
        port_write_s ##0 (state.count >= DEPTH_W[6:0])
        |=> fifo_overrun_flag_out && fifo_byte_count_out == $past(fifo_byte_count_out))
        else $error("overrun not handled");
    overrun_sticky_a: assert property (
        fifo_overrun_flag_out |=> fifo_overrun_flag_out || fifo_clear_out)
        else $error("overrun flag dropped without flush");
    frame_start_a: assert property (
        rx_frame_start_in |=> state.invalid && !state.clashed && state.position == 5'h00)
        else $error("collision info not reset at frame start");
    clash_pos_a: assert property (
        clash_event_in && !state.clashed && !rx_frame_start_in
        && clash_bit_number_in == NUM_W'(CLASH_RANGE)
        |=> state.position == 5'h00 && !state.invalid)
        else $error("thirty-second bit position wrong");
    clash_range_a: assert property (
        clash_event_in && !state.clashed && !rx_frame_start_in
        && clash_bit_number_in > NUM_W'(CLASH_RANGE) |=> state.invalid)
        else $error("out of range collision not flagged");
    clash_clear_a: assert property (
        clear_bits_after_clash_out |-> !keep_bits_after_clash_out && state.clashed)
        else $error("bits cleared without collision");
    clash_discard_a: assert property (
        state.clashed && !state.keep |-> clear_bits_after_clash_out)
        else $error("bits kept after collision");
    keep_write_a: assert property (
        reg_wr_in && reg_addr_in == ADDR_COLLISION_INFO
        |=> keep_bits_after_clash_out == $past(reg_wdata_in[KEEP_BITS_BIT]))
        else $error("keep bit not written");
endmodule

//--- verilog/fifo_framing_collision_pkg.sv
// Constants for the FIFO level, threshold, control, framing and collision registers.
// Assumes an 8-bit register port with 6-bit addresses.
package fifo_framing_collision_pkg;
    // ========================================
    // Register addresses
    localparam logic [5:0] ADDR_FIFO_PORT = 6'h09;
    localparam logic [5:0] ADDR_FIFO_FILL_LEVEL = 6'h0a;
    localparam logic [5:0] ADDR_FIFO_WARNING_THRESHOLD = 6'h0b;
    localparam logic [5:0] ADDR_MISC_CONTROL = 6'h0c;
    localparam logic [5:0] ADDR_BIT_FRAMING_CONTROL = 6'h0d;
    localparam logic [5:0] ADDR_COLLISION_INFO = 6'h0e;
    // ========================================
    // Field positions
    localparam int FIFO_CLEAR_BIT = 7;
    localparam int TIMER_HALT_BIT = 7;
    localparam int TIMER_LAUNCH_BIT = 6;
    localparam int TX_LAUNCH_BIT = 7;
    localparam int RX_OFFSET_LSB = 4;
    localparam int KEEP_BITS_BIT = 7;
    localparam int CLASH_INVALID_BIT = 5;
    // ========================================
    // Reset values and sizes
    localparam logic [5:0] THRESHOLD_RESET = 6'h08;
    localparam logic [7:0] MISC_CONTROL_RESERVED = 8'h10;
    localparam logic KEEP_BITS_RESET = 1'b1;
    localparam logic CLASH_INVALID_RESET = 1'b1;
    localparam int FIFO_DEPTH = 64;
    localparam int CLASH_RANGE = 32;
    localparam int NUM_W = 8;
endpackage

//--- verif/host_model.sv
// Host model: register writes and reads on the decoded register port.
// Assumes strobes are taken on the rising clock edge.
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic clk_in,
    // Register port
    output logic [5:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out,
    input wire logic [7:0] rdata_in
);
    initial begin
        addr_out = 6'h3f;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule

//--- verif/fifo_framing_collision_regs_tb_top.sv
// Bench for the FIFO level, control, framing and collision registers.
// Assumes the host model and the modem pulses are driven at falling edges.
`timescale 1ns/10ps
module fifo_framing_collision_regs_tb_top;
    import fifo_framing_collision_pkg::*;
    localparam logic [5:0] RA [6] = '{6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f};
    localparam logic [7:0] RV [6] = '{8'h00, 8'h08, 8'h10, 8'h00, 8'ha0, 8'h00};
    localparam logic [7:0] NUMS [5] = '{8'h01, 8'h08, 8'h20, 8'h21, 8'h00};
    logic core_clk_in = 1'b0, rst_in = 1'b1, wr, rd, tact = 1'b0, fs = 1'b0, fe = 1'b0;
    logic clash = 1'b0, ovr, clr, nf, ne, th, tl, txl, keep, clrb;
    logic [5:0] addr;
    logic [7:0] wd, rdata, cnum = 8'h00, lf = 8'h43;
    logic [6:0] cnt;
    logic [2:0] fb = 3'h0, offs, txb;
    int error_cnt = 0, checks = 0;
    always #10 core_clk_in = ~core_clk_in;
    host_model host_u (.clk_in(core_clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wd), .rdata_in(rdata));
    fifo_framing_collision_regs #(.DEPTH(64)) dut_u (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wd), .reg_rdata_out(rdata), .transceive_active_in(tact),
        .rx_frame_start_in(fs), .rx_frame_end_in(fe), .rx_final_bits_in(fb),
        .clash_event_in(clash), .clash_bit_number_in(cnum), .fifo_byte_count_out(cnt),
        .fifo_overrun_flag_out(ovr), .fifo_clear_out(clr), .near_full_flag_out(nf),
        .near_empty_flag_out(ne), .timer_halt_out(th), .timer_launch_out(tl),
        .tx_launch_out(txl), .rx_first_bit_offset_out(offs),
        .tx_final_byte_bit_count_out(txb), .keep_bits_after_clash_out(keep),
        .clear_bits_after_clash_out(clrb));
    // ========================================
    // Helpers
    function automatic logic [7:0] lfsr();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    function automatic logic [7:0] flags(input int c, input logic [5:0] t);
        return {6'h00, (64 - c) <= int'(t), c <= int'(t)};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic frame(input logic [7:0] n, input logic en, input logic [2:0] b);
        @(negedge core_clk_in);
        fs = 1'b1;
        @(negedge core_clk_in);
        fs = 1'b0;
        clash = en;
        cnum = n;
        @(negedge core_clk_in);
        cnum = ~n;
        fe = 1'b1;
        fb = b;
        @(negedge core_clk_in);
        clash = 1'b0;
        fe = 1'b0;
        fb = ~b;
    endtask
    task automatic stop_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
    // ========================================
    // Tests
    initial begin
        logic [7:0] d, t, v, n;
        logic inv;
        repeat (3) @(negedge core_clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 6; i++) begin
            host_u.rd(RA[i], d);
            chk("reset value", RV[i], d);
        end
        $display("reset test done");
        t = lfsr();
        host_u.wr(ADDR_FIFO_WARNING_THRESHOLD, t);
        host_u.rd(ADDR_FIFO_WARNING_THRESHOLD, d);
        chk("threshold", {2'b00, t[5:0]}, d);
        for (int i = 1; i <= 65; i++) begin
            host_u.wr(ADDR_FIFO_PORT, lfsr());
            chk("count up", (i > 64) ? 8'd64 : 8'(i), {1'b0, cnt});
            chk("near flags", flags((i > 64) ? 64 : i, t[5:0]), {6'h00, nf, ne});
            chk("overrun", {7'h00, i > 64}, {7'h00, ovr});
        end
        host_u.rd(ADDR_FIFO_FILL_LEVEL, d);
        chk("level read", 8'h40, d);
        host_u.wr(ADDR_FIFO_FILL_LEVEL, 8'h80 | lfsr());
        chk("flush count", 8'h00, {1'b0, cnt});
        chk("flush flags", 8'h01, {6'h00, ovr, clr});
        host_u.rd(ADDR_FIFO_FILL_LEVEL, d);
        chk("flush reads 0", 8'h00, d);
        chk("near empty", flags(0, t[5:0]), {6'h00, nf, ne});
        for (int i = 0; i < 6; i++) begin
            if (i < 2) host_u.wr(ADDR_FIFO_PORT, lfsr());
            else host_u.rd(ADDR_FIFO_PORT, d);
            chk("count", (i < 2) ? 8'(i + 1) : (i < 4) ? 8'(3 - i) : 8'd0, {1'b0, cnt});
        end
        $display("fifo test done");
        for (int i = 0; i < 3; i++) begin
            v = lfsr();
            v[7:6] = {i != 1, i != 0};
            host_u.wr(ADDR_MISC_CONTROL, v);
            chk("timer strobes", {6'h00, v[7], v[6] & ~v[7]}, {6'h00, th, tl});
            host_u.rd(ADDR_MISC_CONTROL, d);
            chk("control read", 8'h10, d);
        end
        $display("timer test done");
        for (int i = 0; i < 8; i++) begin
            v = lfsr();
            tact = i[0];
            host_u.wr(ADDR_BIT_FRAMING_CONTROL, v);
            chk("send trigger", {7'h00, v[7] & tact}, {7'h00, txl});
            chk("framing outs", {1'b0, v[6:4], 1'b0, v[2:0]}, {1'b0, offs, 1'b0, txb});
            host_u.rd(ADDR_BIT_FRAMING_CONTROL, d);
            chk("framing read", {1'b0, v[6:4], 1'b0, v[2:0]}, d);
        end
        host_u.wr(ADDR_BIT_FRAMING_CONTROL, 8'h00);
        $display("framing test done");
        for (int i = 0; i < 8; i++) begin
            n = (i < 5) ? NUMS[i] : lfsr();
            v = lfsr();
            host_u.wr(ADDR_COLLISION_INFO, {i[0], 7'h00});
            frame(n, i != 7, v[2:0]);
            inv = (i == 7) || n < 8'd1 || n > 8'd32;
            host_u.rd(ADDR_COLLISION_INFO, d);
            chk("clash invalid", {i[0], 1'b0, inv, 5'h00}, d & 8'he0);
            if (!inv) chk("clash pos", {3'h0, n[4:0]}, {3'h0, d[4:0]});
            if (!inv) chk("clear after", {7'h00, !i[0]}, {7'h00, clrb});
            chk("keep out", {7'h00, i[0]}, {7'h00, keep});
            host_u.rd(ADDR_MISC_CONTROL, d);
            chk("rx last bits", {5'h02, v[2:0]}, d);
        end
        host_u.wr(ADDR_COLLISION_INFO, 8'h80);
        $display("collision test done");
        stop_test();
    end
endmodule
